/* File: hw/i2cs_params.svh */
// constants for the two-wire register slave port
// assumes inclusion by bare name from the package and design modules
`ifndef I2CS_PARAMS_SVH
`define I2CS_PARAMS_SVH

// ==========================================================
// bus address
`define I2CS_ADDR_HI 6'h34
// ==========================================================
// register index space and disable bit location
`define I2CS_IDX_W 8
`define I2CS_DIS_IDX 8'h6A
`define I2CS_DIS_BIT 4
`define I2CS_REG_RST 8'h00
// ==========================================================
// byte framing
`define I2CS_BITS_PER_BYTE 4'h8
`define I2CS_LINE_IDLE 1'b1

`endif

/* File: hw/i2cs_pkg.sv */
// types shared by the two-wire register slave port
// assumes i2cs_params.svh is on the include path
`include "i2cs_params.svh"

package i2cs_pkg;
  // ==========================================================
  // protocol phases
  typedef enum logic [2:0] {
    I2CS_IDLE,
    I2CS_ADDR,
    I2CS_ADDR_ACK,
    I2CS_WR_BYTE,
    I2CS_WR_ACK,
    I2CS_RD_BYTE,
    I2CS_RD_ACK,
    I2CS_IGNORE
  } i2cs_phase_t;

  // ==========================================================
  // whole state of the protocol engine
  typedef struct packed {
    i2cs_phase_t ph;
    logic scl_p;
    logic sda_p;
    logic [7:0] sh;
    logic [3:0] cnt;
    logic rw;
    logic first;
    logic ack;
    logic [7:0] idx;
    logic [7:0] tx;
    logic sda_oe;
    logic scl_oe;
    logic busy;
    logic wr_stb;
    logic [7:0] wr_idx;
    logic [7:0] wr_data;
  } i2cs_state_t;
endpackage

/* File: hw/i2cs_sync.sv */
// two-flop synchroniser for pin inputs
// assumes the inputs are asynchronous to clk and idle at RST_VAL
`timescale 1ns/1ps

module i2cs_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '1
) (
  input wire logic clk, // core clock
  input wire logic reset, // synchronous, active high
  input wire logic [W-1:0] d, // raw pin levels
  output logic [W-1:0] q // synchronised levels
);
  logic [W-1:0] meta_ff;

  // ==========================================================
  // first stage is read only by the second
  always_ff @(posedge clk) begin
    if (reset) begin
      meta_ff <= RST_VAL;
      q <= RST_VAL;
    end else begin
      meta_ff <= d;
      q <= meta_ff;
    end
  end
endmodule

/* File: hw/i2cs_regfile.sv */
// register bank reached through the two-wire port
// assumes one write and one combinational read per cycle
`timescale 1ns/1ps
`include "i2cs_params.svh"

module i2cs_regfile (
  input wire logic clk, // core clock
  input wire logic reset, // synchronous, active high
  input wire logic wr_en, // one-cycle write strobe
  input wire logic [7:0] wr_idx, // write index
  input wire logic [7:0] wr_data, // write data
  input wire logic [7:0] rd_idx, // read index
  output logic [7:0] rd_data, // read data, same cycle
  output logic dis // two-wire disable bit
);
  logic [7:0] mem_ff [0:255];
  logic dis_ff;

  // ==========================================================
  // storage; reset clears the whole bank so reads are defined
  always_ff @(posedge clk) begin
    if (reset) begin
      for (int i = 0; i < 256; i++) begin
        mem_ff[i] <= `I2CS_REG_RST;
      end
      dis_ff <= 1'b0;
    end else if (wr_en) begin
      mem_ff[wr_idx] <= wr_data;
      if (wr_idx == `I2CS_DIS_IDX) begin
        dis_ff <= wr_data[`I2CS_DIS_BIT];
      end
    end
  end

  // disable bit is also kept in the array so it reads back
  assign rd_data = mem_ff[rd_idx];
  assign dis = dis_ff;
endmodule

/* File: hw/i2cs_top.sv */
// two-wire slave port giving a bus master access to the register bank
// assumes open-drain pins resolved outside; SCL is oversampled on CLK
//
// Behaviour
// RULE_01: address is fixed upper six bits plus address select pin level.
// RULE_02: select low gives 1101000, select high gives 1101001.
// RULE_03: port only ever acts as slave, never creates bus conditions.
// RULE_04: master keeps the bus at or below 400 kHz; the bench master model runs at about 2.25 MHz.
// RULE_05: SDA falling while SCL high is START and opens a transaction.
// RULE_06: SDA rising while SCL high is STOP, ends transaction, frees bus.
// RULE_07: bus busy from START to STOP; repeated START keeps it busy.
// RULE_08: bytes are eight bits, each followed by acknowledge, unlimited count.
// RULE_09: receiver acknowledges by holding SDA low through ninth clock high.
// RULE_10: busy device may hold SCL low; master waits for release.
// RULE_11: after START master sends address and direction, then releases SDA.
// RULE_12: SDA changes only while SCL low except START and STOP.
// RULE_13: write is address+0, index byte, data byte, each acknowledged.
// RULE_14: further write bytes go to successive indices.
// RULE_15: read sets index by write, repeated START with direction 1.
// RULE_16: master ends read with not-acknowledge then STOP.
// RULE_17: clock, data and select pins double as serial peripheral pins.
// RULE_18: disable bit set by host stops the port entering two-wire mode.
// RULE_19: master acknowledge during read advances index and sends next byte.
// RULE_20: address mismatch leaves acknowledge undriven, rest ignored.
`timescale 1ns/1ps
`include "i2cs_params.svh"

module i2cs_top (
  input wire logic CLK, // 125 MHz core clock
  input wire logic RESET, // synchronous, active high
  input wire logic SCL_I, // bus clock level
  output logic SCL_O, // bus clock drive value, always low
  output logic SCL_OE, // high while stretching the clock
  input wire logic SDA_I, // bus data level
  output logic SDA_O, // bus data drive value, always low
  output logic SDA_OE, // high while pulling data low
  input wire logic ADDR_SEL_I, // address select pin level
  input wire logic HOLD, // core not ready, stretch the clock
  output logic BUSY, // transaction in progress
  output logic WR_STB, // one-cycle register write strobe
  output logic [7:0] WR_IDX, // register index written
  output logic [7:0] WR_DATA, // data written
  output logic TWO_WIRE_DIS // disable bit state
);
  import i2cs_pkg::*;

  i2cs_state_t st_ff;
  i2cs_state_t nxt_st;
  logic scl_s;
  logic sda_s;
  logic sel_s;
  logic dis;
  logic [7:0] rd_data;
  logic zero_ff;
  logic start_c;
  logic stop_c;
  logic scl_rise;
  logic scl_fall;
  logic addr_match;

  // ==========================================================
  // pin synchronisers; the pins share lines with another port
  i2cs_sync #(.W(3), .RST_VAL(3'h7)) u_sync (
    .clk(CLK),
    .reset(RESET),
    .d({SCL_I, SDA_I, ADDR_SEL_I}),
    .q({scl_s, sda_s, sel_s})
  );

  // ==========================================================
  // register bank
  i2cs_regfile u_regs (
    .clk(CLK),
    .reset(RESET),
    .wr_en(st_ff.wr_stb),
    .wr_idx(st_ff.wr_idx),
    .wr_data(st_ff.wr_data),
    .rd_idx(st_ff.idx),
    .rd_data(rd_data),
    .dis(dis)
  );

  // ==========================================================
  // bus condition detection on synchronised levels
  assign start_c = scl_s && st_ff.scl_p && st_ff.sda_p && !sda_s; // RULE_05
  assign stop_c = scl_s && st_ff.scl_p && !st_ff.sda_p && sda_s; // RULE_06
  assign scl_rise = scl_s && !st_ff.scl_p;
  assign scl_fall = !scl_s && st_ff.scl_p;
  // select pin is only an address input here; the other port owns it otherwise
  assign addr_match = (st_ff.sh[7:1] == {`I2CS_ADDR_HI, sel_s}); // RULE_01 RULE_02 RULE_17

  // ==========================================================
  // protocol engine next state
  always_comb begin
    nxt_st = st_ff;
    nxt_st.scl_p = scl_s;
    nxt_st.sda_p = sda_s;
    nxt_st.wr_stb = 1'b0;
    // stretch only once SCL is already low, so no clock edge is created
    // a foreign transaction is not stretched once its address is refused, its master may not expect it
    nxt_st.scl_oe = HOLD && st_ff.busy && (st_ff.ph != I2CS_IGNORE) // RULE_10 RULE_03
      && (!scl_s || st_ff.scl_oe); // RULE_20
    if (stop_c) begin
      nxt_st.ph = I2CS_IDLE; // RULE_06
      nxt_st.busy = 1'b0;
      nxt_st.sda_oe = 1'b0;
      nxt_st.scl_oe = 1'b0;
    end else if (start_c && !dis) begin
      // a repeated start lands here too and keeps the bus busy
      nxt_st.ph = I2CS_ADDR; // RULE_05 RULE_07 RULE_18
      nxt_st.busy = 1'b1;
      nxt_st.cnt = 4'h0;
      nxt_st.sda_oe = 1'b0;
    end else begin
      unique case (st_ff.ph)
        I2CS_IDLE, I2CS_IGNORE: begin
          nxt_st.sda_oe = 1'b0; // RULE_20
        end
        I2CS_ADDR: begin
          if (scl_rise) begin
            nxt_st.sh = {st_ff.sh[6:0], sda_s}; // RULE_11
            nxt_st.cnt = st_ff.cnt + 4'h1;
          end else if (scl_fall && st_ff.cnt == `I2CS_BITS_PER_BYTE) begin
            if (addr_match) begin
              nxt_st.rw = st_ff.sh[0]; // RULE_15
              nxt_st.sda_oe = 1'b1; // RULE_09
              nxt_st.ph = I2CS_ADDR_ACK;
            end else begin
              nxt_st.ph = I2CS_IGNORE; // RULE_20
            end
          end
        end
        I2CS_ADDR_ACK: begin
          if (scl_fall) begin
            nxt_st.cnt = 4'h0;
            if (st_ff.rw) begin
              nxt_st.tx = rd_data;
              nxt_st.sda_oe = !rd_data[7];
              nxt_st.ph = I2CS_RD_BYTE;
            end else begin
              nxt_st.sda_oe = 1'b0;
              nxt_st.first = 1'b1; // RULE_13
              nxt_st.ph = I2CS_WR_BYTE;
            end
          end
        end
        I2CS_WR_BYTE: begin
          if (scl_rise) begin
            nxt_st.sh = {st_ff.sh[6:0], sda_s};
            nxt_st.cnt = st_ff.cnt + 4'h1;
          end else if (scl_fall && st_ff.cnt == `I2CS_BITS_PER_BYTE) begin
            nxt_st.sda_oe = 1'b1; // RULE_08 RULE_09
            nxt_st.ph = I2CS_WR_ACK;
            nxt_st.first = 1'b0;
            if (st_ff.first) begin
              nxt_st.idx = st_ff.sh; // RULE_13
            end else begin
              nxt_st.wr_stb = 1'b1;
              nxt_st.wr_idx = st_ff.idx;
              nxt_st.wr_data = st_ff.sh;
              nxt_st.idx = st_ff.idx + 8'h01; // RULE_14
            end
          end
        end
        I2CS_WR_ACK: begin
          if (scl_fall) begin
            nxt_st.sda_oe = 1'b0;
            nxt_st.cnt = 4'h0;
            nxt_st.ph = I2CS_WR_BYTE; // RULE_08
          end
        end
        I2CS_RD_BYTE: begin
          // data changes only on the falling edge of SCL
          if (scl_fall) begin
            nxt_st.cnt = st_ff.cnt + 4'h1;
            if (st_ff.cnt == `I2CS_BITS_PER_BYTE - 4'h1) begin
              nxt_st.sda_oe = 1'b0;
              nxt_st.ph = I2CS_RD_ACK;
            end else begin
              nxt_st.tx = {st_ff.tx[6:0], 1'b0};
              nxt_st.sda_oe = !st_ff.tx[6]; // RULE_12
            end
          end
        end
        I2CS_RD_ACK: begin
          if (scl_rise) begin
            nxt_st.ack = !sda_s;
            if (!sda_s) begin
              nxt_st.idx = st_ff.idx + 8'h01; // RULE_19
            end
          end else if (scl_fall) begin
            nxt_st.cnt = 4'h0;
            if (st_ff.ack) begin
              nxt_st.tx = rd_data; // RULE_19
              nxt_st.sda_oe = !rd_data[7];
              nxt_st.ph = I2CS_RD_BYTE;
            end else begin
              nxt_st.ph = I2CS_IGNORE; // RULE_16
            end
          end
        end
      endcase
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge CLK) begin
    if (RESET) begin
      st_ff <= '0;
      st_ff.ph <= I2CS_IDLE;
      st_ff.scl_p <= `I2CS_LINE_IDLE;
      st_ff.sda_p <= `I2CS_LINE_IDLE;
      zero_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      zero_ff <= 1'b0;
    end
  end

  // ==========================================================
  // outputs straight from flops
  assign SCL_O = zero_ff;
  assign SDA_O = zero_ff;
  assign SCL_OE = st_ff.scl_oe;
  assign SDA_OE = st_ff.sda_oe;
  assign BUSY = st_ff.busy;
  assign WR_STB = st_ff.wr_stb;
  assign WR_IDX = st_ff.wr_idx;
  assign WR_DATA = st_ff.wr_data;
  assign TWO_WIRE_DIS = dis;

  // ==========================================================
  // checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);

  sequence addr_byte_done;
    st_ff.ph == I2CS_ADDR && scl_fall && st_ff.cnt == `I2CS_BITS_PER_BYTE && !stop_c && !start_c;
  endsequence

  sequence wr_byte_done;
    st_ff.ph == I2CS_WR_BYTE && scl_fall && st_ff.cnt == `I2CS_BITS_PER_BYTE && !start_c;
  endsequence

  sequence rd_turn;
    st_ff.ph == I2CS_ADDR_ACK && st_ff.rw && scl_fall;
  endsequence

  sequence rd_next;
    st_ff.ph == I2CS_RD_ACK && st_ff.ack && scl_fall;
  endsequence

  sequence rd_nack;
    st_ff.ph == I2CS_RD_ACK && !st_ff.ack && scl_fall;
  endsequence

  chk_start_opens: assert property ((start_c && !stop_c && !dis) |=> // RULE_05
    (st_ff.ph == I2CS_ADDR && BUSY)) else $error("start did not open a transaction");
  chk_stop_frees: assert property (stop_c |=> (!BUSY && !SDA_OE && !SCL_OE)) // RULE_06
    else $error("stop did not free the bus");
  chk_busy_holds: assert property ((BUSY && !stop_c) |=> BUSY) // RULE_07
    else $error("bus dropped busy without stop");
  chk_addr_match: assert property ((addr_byte_done and addr_match) |=> // RULE_01
    (st_ff.ph == I2CS_ADDR_ACK && SDA_OE)) else $error("matching address not acknowledged");
  chk_addr_miss: assert property ((addr_byte_done and !addr_match) |=> // RULE_20
    (st_ff.ph == I2CS_IGNORE && !SDA_OE)) else $error("foreign address acknowledged");
  chk_ignore_quiet: assert property (st_ff.ph == I2CS_IGNORE |-> !SDA_OE) // RULE_20
    else $error("data driven while ignoring");
  chk_byte_ack: assert property (wr_byte_done |=> (st_ff.ph == I2CS_WR_ACK && SDA_OE)) // RULE_08
    else $error("written byte not acknowledged");
  chk_burst_index: assert property (WR_STB |-> st_ff.idx == WR_IDX + 8'h01) // RULE_14
    else $error("write index did not advance");
  chk_read_index: assert property ((st_ff.ph == I2CS_RD_ACK && scl_rise && !sda_s // RULE_19
    && !stop_c && !start_c) |=> st_ff.idx == $past(st_ff.idx) + 8'h01)
    else $error("read index did not advance");
  chk_slave_only: assert property (!BUSY |-> !SCL_OE) // RULE_03
    else $error("clock pulled outside a transaction");
  chk_stretch_low: assert property ($rose(SCL_OE) |-> !$past(scl_s)) // RULE_10
    else $error("stretch began with clock high");
  chk_disabled_idle: assert property ((dis && start_c && !BUSY) |=> !BUSY) // RULE_18
    else $error("disabled port entered a transaction");
  chk_sda_on_low: assert property ((st_ff.ph == I2CS_RD_BYTE && $changed(SDA_OE)) // RULE_12
    |-> !$past(scl_s)) else $error("read data changed with clock high");
  // write path: the first byte only moves the index, later bytes are stored
  chk_index_load: assert property ((wr_byte_done and st_ff.first) |=> // RULE_13
    (!WR_STB && st_ff.idx == $past(st_ff.sh))) else $error("index byte not taken");
  chk_wr_strobe: assert property ((wr_byte_done and !st_ff.first) |=> // RULE_13
    (WR_STB && WR_DATA == $past(st_ff.sh))) else $error("data byte not stored");
  // the acknowledge is let go at the end of the ninth clock so the master can go on
  chk_ack_release: assert property ((st_ff.ph == I2CS_WR_ACK && scl_fall) |=> // RULE_09
    !SDA_OE) else $error("acknowledge held past the ninth clock");
  // read path: each byte is loaded from the bank as the previous bit time ends
  chk_read_load: assert property (rd_turn |=> // RULE_15
    (st_ff.ph == I2CS_RD_BYTE && st_ff.tx == $past(rd_data)))
    else $error("read byte not loaded");
  chk_next_load: assert property (rd_next |=> // RULE_19
    (st_ff.ph == I2CS_RD_BYTE && st_ff.tx == $past(rd_data)))
    else $error("next byte not loaded");
  chk_master_ack: assert property (st_ff.ph == I2CS_RD_ACK |-> !SDA_OE) // RULE_09
    else $error("data driven during the master acknowledge");
  chk_nack_release: assert property (rd_nack |=> // RULE_16
    (st_ff.ph == I2CS_IGNORE && !SDA_OE)) else $error("port kept sending after not-acknowledge");
  chk_ignore_noclk: assert property (st_ff.ph == I2CS_IGNORE |=> !SCL_OE) // RULE_20
    else $error("clock stretched for a foreign transaction");
endmodule

/* File: test/i2cs_master.sv */
// two-wire bus master model driving the slave port's pins
// assumes the bench resolves both open-drain wires with pull-ups
`timescale 1ns/1ps

module i2cs_master (
  input wire logic lclk, // link clock, 12 ns
  input wire logic scl, // resolved clock wire
  input wire logic sda, // resolved data wire
  output logic scl_low, // pulls the clock wire low
  output logic sda_low // pulls the data wire low
);
  // ==========================================================
  // timing: 16 link cycles a half bit gives a 444 ns bit, about 2.25 MHz, well above 400 kHz
  localparam int HALF = 16;
  int stretch;

  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
    stretch = 0;
  end

  task automatic half();
    repeat (HALF) @(posedge lclk);
  endtask

  // release the clock and wait out any stretch, bounded so a stuck slave cannot hang us
  task automatic clk_hi();
    int n;
    n = 0;
    scl_low <= 1'b0;
    @(posedge lclk);
    while (scl !== 1'b1 && n < 5000) begin
      @(posedge lclk);
      n++;
      stretch++;
    end
    half();
  endtask

  // data moves only while the clock is low; a few cycles of hold after the fall
  task automatic bit_io(input logic b, output logic r);
    sda_low <= ~b;
    half();
    clk_hi();
    r = sda;
    scl_low <= 1'b1;
    repeat (4) @(posedge lclk);
  endtask

  // ==========================================================
  // bus conditions, also used for repeated start
  task automatic start();
    sda_low <= 1'b0;
    half();
    clk_hi();
    sda_low <= 1'b1;
    half();
    scl_low <= 1'b1;
    repeat (4) @(posedge lclk);
  endtask

  task automatic stop();
    sda_low <= 1'b1;
    half();
    clk_hi();
    sda_low <= 1'b0;
    half();
  endtask

  // ==========================================================
  // byte transfers, msb first, ninth clock for acknowledge
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
    end
    bit_io(1'b1, r);
    ack = ~r;
  endtask

  task automatic rd_byte(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, d[i]);
    end
    bit_io(~ack, r);
  endtask
endmodule

/* File: test/i2c_slave_register_port_tb.sv */
// self-checking bench for the two-wire register slave port
// assumes i2cs_master as the bus master and open-drain wires resolved here
`timescale 1ns/1ps
`include "i2cs_params.svh"

module i2c_slave_register_port_tb;
  logic clk, reset, lclk, addr_sel, hold;
  logic scl_o, scl_oe, sda_o, sda_oe, busy, wr_stb, dis;
  logic [7:0] wr_idx, wr_data;
  logic m_scl_low, m_sda_low, a;
  logic [7:0] d;
  logic [15:0] wq[$];
  int miscompares, n_tests;
  wire scl = (scl_oe ? scl_o : 1'b1) & ~m_scl_low;
  wire sda = (sda_oe ? sda_o : 1'b1) & ~m_sda_low;

  i2cs_top dut_u (.CLK(clk), .RESET(reset), .SCL_I(scl), .SCL_O(scl_o), .SCL_OE(scl_oe),
    .SDA_I(sda), .SDA_O(sda_o), .SDA_OE(sda_oe), .ADDR_SEL_I(addr_sel), .HOLD(hold),
    .BUSY(busy), .WR_STB(wr_stb), .WR_IDX(wr_idx), .WR_DATA(wr_data), .TWO_WIRE_DIS(dis));
  i2cs_master m_u (.lclk(lclk), .scl(scl), .sda(sda), .scl_low(m_scl_low),
    .sda_low(m_sda_low));

  // ==========================================================
  // clocks: link clock offset so the two never line up
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    lclk = 1'b0;
    #3;
    forever #6 lclk = ~lclk;
  end

  // register writes collected as {index, data}
  always @(posedge clk) begin
    if (wr_stb === 1'b1) begin
      wq.push_back({wr_idx, wr_data});
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("tests=%0d miscompares=%0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ==========================================================
  // scenarios
  task automatic t_burst_write();
    m_u.start();
    m_u.wr_byte(8'hD0, a);
    check(16'(a), 16'h1);
    check(16'(busy), 16'h1);
    m_u.wr_byte(8'h10, a);
    check(16'(a), 16'h1);
    m_u.wr_byte(8'hA5, a);
    check(16'(a), 16'h1);
    m_u.wr_byte(8'h3C, a);
    check(16'(a), 16'h1);
    m_u.stop();
    repeat (8) @(posedge clk);
    check(16'(busy), 16'h0);
    check(16'(wq.size()), 16'h2);
    check(wq.pop_front(), 16'h10A5);
    check(wq.pop_front(), 16'h113C);
  endtask

  // index written, then repeated start turns the bus round for reading
  task automatic t_read();
    m_u.start();
    m_u.wr_byte(8'hD0, a);
    m_u.wr_byte(8'h10, a);
    m_u.start();
    check(16'(busy), 16'h1);
    m_u.wr_byte(8'hD1, a);
    check(16'(a), 16'h1);
    m_u.rd_byte(1'b1, d);
    check(16'(d), 16'hA5);
    m_u.rd_byte(1'b0, d);
    check(16'(d), 16'h3C);
    m_u.stop();
    repeat (8) @(posedge clk);
    check(16'(wq.size()), 16'h0);
    check(16'({sda_o, scl_o}), 16'h0);
  endtask

  // select high moves the address; the old one is refused and ignored
  task automatic t_addr_sel();
    addr_sel <= 1'b1;
    repeat (8) @(posedge clk);
    m_u.start();
    m_u.wr_byte(8'hD0, a);
    check(16'(a), 16'h0);
    m_u.wr_byte(8'h20, a);
    check(16'(a), 16'h0);
    m_u.stop();
    m_u.start();
    m_u.wr_byte(8'hD2, a);
    check(16'(a), 16'h1);
    m_u.wr_byte(8'h20, a);
    m_u.wr_byte(8'h77, a);
    m_u.stop();
    repeat (8) @(posedge clk);
    check(16'(wq.size()), 16'h1);
    check(wq.pop_front(), 16'h2077);
    addr_sel <= 1'b0;
    repeat (8) @(posedge clk);
  endtask

  // core not ready: the port must hold the clock low until hold drops
  task automatic t_stretch();
    m_u.stretch = 0;
    m_u.start();
    @(posedge clk);
    hold <= 1'b1;
    fork
      begin
        repeat (300) @(posedge clk);
        check(16'(scl_oe), 16'h1);
        hold <= 1'b0;
      end
      m_u.wr_byte(8'hD0, a);
    join
    check(16'(a), 16'h1);
    check(16'(m_u.stretch > 100), 16'h1);
    m_u.stop();
  endtask

  // disable bit set by the host; later starts are refused
  task automatic t_disable();
    m_u.start();
    m_u.wr_byte(8'hD0, a);
    m_u.wr_byte(`I2CS_DIS_IDX, a);
    m_u.wr_byte(8'h10, a);
    m_u.stop();
    repeat (8) @(posedge clk);
    check(16'(dis), 16'h1);
    check(wq.pop_front(), {`I2CS_DIS_IDX, 8'h10});
    m_u.start();
    m_u.wr_byte(8'hD0, a);
    check(16'(a), 16'h0);
    m_u.stop();
    check(16'(wq.size()), 16'h0);
  endtask

  // ==========================================================
  // main sequence and watchdog
  initial begin
    miscompares = 0;
    n_tests = 0;
    reset = 1'b1;
    addr_sel = 1'b0;
    hold = 1'b0;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    repeat (4) @(posedge clk);
    check(16'({scl_oe, sda_oe, busy, wr_stb, dis}), 16'h0);
    t_burst_write();
    t_read();
    t_addr_sel();
    t_stretch();
    t_disable();
    summarize();
  end

  // a run of 19 bytes needs near 90 us; allow well over that
  initial begin
    #600000;
    miscompares++;
    summarize();
  end
endmodule
